// >>> tcg_gate.sv
// Purpose: torque cutoff gating of one decentral servo drive
// Assumes: the local-input fitting strap is stable around reset release
// Notes:   status outputs are informational, never a safety decision
//
// Behaviour
// - power stage released only while the selected enable high (local if fitted, else string)
// - local falling edge blocks energy within 10 ms when local is fitted
// - string falling edge blocks energy within 10 ms when local is not fitted
// - local-fitted drive ignores string enable except at the string status output
// - torque needs enable high and hardware enable
// - short, well spaced low test pulses ignored
// - wide or frequent pulses switch to safe state
// - cutoff during run means uncontrolled coast, no braking
// - enable attempts refused while cutoff enable removed
// - string cutoff changes string status level
// - status high when enable absent, low present
`timescale 1ns/1ps
`default_nettype none
module tcg_gate
    import tcg_pkg::*;
#(
    // long counts, shorten for simulation
    parameter logic [TCG_WIDTH_W-1:0] WIDTH_CYC = TCG_WIDTH_W'(TCG_PULSE_MAX_CYC),
    parameter logic [TCG_GAP_W-1:0] GAP_CYC = TCG_GAP_W'(TCG_PULSE_GAP_CYC),
    parameter logic [TCG_REACT_W-1:0] REACT_CYC = TCG_REACT_W'(TCG_REACT_CYC)
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // cutoff enable inputs
    input wire logic LOCAL_ENABLE_I,
    input wire logic STRING_ENABLE_I,
    // configuration strap and drive control
    input wire logic LOCAL_FITTED_I,
    input wire logic STRING_STRING_HARDWARE_ENABLE_I,
    input wire logic DRIVE_ENABLE_REQ_I,
    // power stage and torque
    output logic POWER_STAGE_EN_O,
    output logic TORQUE_EN_O,
    output logic DRIVE_ENABLED_O,
    output logic COAST_O,
    // status and events
    output logic CUTOFF_STATUS_O,
    output logic STRING_STATUS_O,
    output logic CUTOFF_EVENT_O,
    output logic ENABLE_REFUSED_O,
    output logic TEST_PULSE_TRIP_O
);

    // channel views and raw inputs
    logic [TCG_NUM_CH-1:0] raw_in;
    tcg_chan_t chan [TCG_NUM_CH];

    // strap capture
    logic fitted_reg;
    logic fitted_seen_reg;

    // gating
    logic sel_ok;
    logic stage_ok;
    logic stage_prev_reg;
    logic req_prev_reg;
    logic req_rise;

    // drive enable state
    tcg_state_t state_reg;
    tcg_state_t state_next;

    // registered outputs
    logic power_en_reg;
    logic torque_en_reg;
    logic drive_en_reg;
    logic coast_reg;
    logic local_status_reg;
    logic string_status_reg;
    logic event_reg;
    logic refused_reg;
    logic trip_reg;

    // state is a valid enable state for the drive
    function automatic logic is_running(input tcg_state_t st);
        is_running = (st == TCG_ST_RUN);
    endfunction

    // cutoff engaged in this state
    function automatic logic is_cut(input tcg_state_t st);
        is_cut = (st == TCG_ST_BLOCKED) || (st == TCG_ST_COAST);
    endfunction

    assign raw_in[TCG_CH_LOCAL] = LOCAL_ENABLE_I;
    assign raw_in[TCG_CH_STRING] = STRING_ENABLE_I;

    // one filter per enable channel, local and string alike
    genvar gi;
    generate
        for (gi = 0; gi < TCG_NUM_CH; gi++) begin : g_chan
            tcg_pulse_filter #(
                .WIDTH_CYC(WIDTH_CYC),
                .GAP_CYC(GAP_CYC),
                .REACT_CYC(REACT_CYC)
            ) u_filter (
                .clk_i(CLK_I),
                .rstn_i(RSTN_I),
                .raw_i(raw_in[gi]),
                .chan_o(chan[gi])
            );
        end
    endgenerate

    // strap caught on the first edge after release, not by the reset
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            fitted_reg <= 1'b0;
            fitted_seen_reg <= 1'b0;
        end else if (!fitted_seen_reg) begin
            fitted_reg <= LOCAL_FITTED_I;
            fitted_seen_reg <= 1'b1;
        end
    end

    // a local-fitted drive looks only at its own input
    assign sel_ok = fitted_reg ? chan[TCG_CH_LOCAL].ok : chan[TCG_CH_STRING].ok;
    // nothing is released before the strap is known
    assign stage_ok = fitted_seen_reg & sel_ok;

    // edge history
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            stage_prev_reg <= 1'b0;
            req_prev_reg <= 1'b0;
        end else begin
            stage_prev_reg <= stage_ok;
            req_prev_reg <= DRIVE_ENABLE_REQ_I;
        end
    end

    assign req_rise = DRIVE_ENABLE_REQ_I & ~req_prev_reg;

    // next state of the drive enable
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            TCG_ST_BLOCKED: begin
                if (stage_ok) begin
                    state_next = TCG_ST_READY;
                end
            end
            TCG_ST_READY: begin
                if (!stage_ok) begin
                    state_next = TCG_ST_BLOCKED;
                end else if (DRIVE_ENABLE_REQ_I) begin
                    state_next = TCG_ST_RUN;
                end
            end
            TCG_ST_RUN: begin
                if (!stage_ok) begin
                    // cutoff during run: no ramp, the motor coasts
                    state_next = TCG_ST_COAST;
                end else if (!DRIVE_ENABLE_REQ_I) begin
                    state_next = TCG_ST_READY;
                end
            end
            TCG_ST_COAST: begin
                // held disabled until the enable is back
                if (stage_ok) begin
                    state_next = TCG_ST_READY;
                end
            end
            default: begin
                state_next = TCG_ST_BLOCKED;
            end
        endcase
    end

    // state register
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_reg <= TCG_ST_BLOCKED;
        end else begin
            state_reg <= state_next;
        end
    end

    // power stage follows the filtered enable every cycle
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            power_en_reg <= 1'b0;
        end else begin
            power_en_reg <= stage_ok;
        end
    end

    // torque only with enable, hardware enable and a running drive
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            torque_en_reg <= 1'b0;
        end else begin
            torque_en_reg <= stage_ok & STRING_STRING_HARDWARE_ENABLE_I & is_running(state_next);
        end
    end

    // drive enable and coast indication
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            drive_en_reg <= 1'b0;
            coast_reg <= 1'b0;
        end else begin
            drive_en_reg <= is_running(state_next);
            coast_reg <= (state_next == TCG_ST_COAST);
        end
    end

    // a request made while the enable is off is refused and flagged
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            refused_reg <= 1'b0;
        end else begin
            refused_reg <= req_rise & ~stage_ok;
        end
    end

    // status levels: high while the enable is absent
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            local_status_reg <= 1'b1;
            string_status_reg <= 1'b1;
        end else begin
            local_status_reg <= ~chan[TCG_CH_LOCAL].ok;
            string_status_reg <= ~chan[TCG_CH_STRING].ok;
        end
    end

    // one-cycle event when the cutoff engages
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            event_reg <= 1'b0;
        end else begin
            event_reg <= stage_prev_reg & ~stage_ok & ~is_cut(state_reg);
        end
    end

    // one-cycle flag when a test pulse breaks the tolerance
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            trip_reg <= 1'b0;
        end else if (fitted_reg) begin
            trip_reg <= chan[TCG_CH_LOCAL].width_trip | chan[TCG_CH_LOCAL].gap_trip;
        end else begin
            trip_reg <= chan[TCG_CH_STRING].width_trip | chan[TCG_CH_STRING].gap_trip;
        end
    end

    // output drive
    assign POWER_STAGE_EN_O = power_en_reg;
    assign TORQUE_EN_O = torque_en_reg;
    assign DRIVE_ENABLED_O = drive_en_reg;
    assign COAST_O = coast_reg;
    assign CUTOFF_STATUS_O = local_status_reg;
    assign STRING_STATUS_O = string_status_reg;
    assign CUTOFF_EVENT_O = event_reg;
    assign ENABLE_REFUSED_O = refused_reg;
    assign TEST_PULSE_TRIP_O = trip_reg;

endmodule // tcg_gate
`default_nettype wire

// >>> tcg_pkg.sv
// Purpose: shared constants and types of the torque cutoff gating block
// Assumes: 200 MHz core clock
// Notes:   times are kept in their own unit, cycle counts derive from them
package tcg_pkg;

    // clock rate
    localparam int TCG_CLK_HZ = 200_000_000;
    localparam int TCG_HZ_PER_MS = TCG_CLK_HZ / 1000;
    localparam int TCG_HZ_PER_US = TCG_CLK_HZ / 1_000_000;

    // longest tolerated low test pulse, rounded down to cycles
    localparam int TCG_PULSE_MAX_US = 300;
    localparam int TCG_PULSE_MAX_CYC = TCG_HZ_PER_US * TCG_PULSE_MAX_US;

    // least spacing between tolerated pulses, rounded down to cycles
    localparam int TCG_PULSE_GAP_MS = 200;
    localparam int TCG_PULSE_GAP_CYC = TCG_HZ_PER_MS * TCG_PULSE_GAP_MS;

    // longest reaction from falling enable to blocked stage
    localparam int TCG_REACT_MS = 10;
    localparam int TCG_REACT_CYC = TCG_HZ_PER_MS * TCG_REACT_MS;

    // counter widths
    localparam int TCG_WIDTH_W = 17;
    localparam int TCG_GAP_W = 27;
    localparam int TCG_REACT_W = 22;

    // channel indices
    localparam int TCG_CH_LOCAL = 0;
    localparam int TCG_CH_STRING = 1;
    localparam int TCG_NUM_CH = 2;

    // drive enable states, gray along blocked-ready-run-coast
    typedef enum logic [1:0] {
        TCG_ST_BLOCKED = 2'b00,
        TCG_ST_READY = 2'b01,
        TCG_ST_RUN = 2'b11,
        TCG_ST_COAST = 2'b10
    } tcg_state_t;

    // filtered view of one enable channel
    typedef struct packed {
        logic ok;
        logic level;
        logic width_trip;
        logic gap_trip;
    } tcg_chan_t;

endpackage : tcg_pkg

// >>> tcg_pulse_filter.sv
// Purpose: synchronise one enable input and tolerate short test pulses
// Assumes: raw input may change at any time relative to the clock
// Notes:   ok stays low after reset until the input has been seen high for WIDTH_CYC cycles
`timescale 1ns/1ps
`default_nettype none
module tcg_pulse_filter
    import tcg_pkg::*;
#(
    parameter logic [TCG_WIDTH_W-1:0] WIDTH_CYC = TCG_WIDTH_W'(TCG_PULSE_MAX_CYC),
    parameter logic [TCG_GAP_W-1:0] GAP_CYC = TCG_GAP_W'(TCG_PULSE_GAP_CYC),
    parameter logic [TCG_REACT_W-1:0] REACT_CYC = TCG_REACT_W'(TCG_REACT_CYC)
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // raw enable level
    input wire logic raw_i,
    // filtered channel view
    output tcg_chan_t chan_o
);

    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic [TCG_REACT_W-1:0] low_cnt_reg;
    logic [TCG_WIDTH_W-1:0] hi_cnt_reg;
    logic [TCG_GAP_W-1:0] gap_cnt_reg;
    logic trip_reg;
    logic width_hit;
    logic react_hit;
    logic gap_hit;
    logic fall;
    logic rise;
    logic hold_done;

    // two-stage synchroniser, first stage read only by the second
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            sync1_reg <= raw_i;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign fall = prev_reg & ~sync2_reg;
    assign rise = ~prev_reg & sync2_reg;

    // low width counter, saturating
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            low_cnt_reg <= '0;
        end else if (sync2_reg) begin
            low_cnt_reg <= '0;
        end else if (low_cnt_reg != '1) begin
            low_cnt_reg <= low_cnt_reg + 1'b1;
        end
    end

    // spacing since last pulse end, starts saturated so a first pulse passes
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gap_cnt_reg <= '1;
        end else if (rise) begin
            gap_cnt_reg <= '0;
        end else if (gap_cnt_reg != '1) begin
            gap_cnt_reg <= gap_cnt_reg + 1'b1;
        end
    end

    // high hold before release, so a short dip after a trip cannot re-arm
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hi_cnt_reg <= '0;
        end else if (!sync2_reg) begin
            hi_cnt_reg <= '0;
        end else if (!hold_done) begin
            hi_cnt_reg <= hi_cnt_reg + 1'b1;
        end
    end

    assign hold_done = (hi_cnt_reg == WIDTH_CYC);
    // pulse too wide: trips on its width-th low cycle
    assign width_hit = ~sync2_reg & (low_cnt_reg == TCG_REACT_W'(WIDTH_CYC - 1'b1));
    // safety net in case the width limit is set beyond the reaction time
    assign react_hit = ~sync2_reg & (low_cnt_reg == REACT_CYC - 1'b1);
    // pulse too soon after the previous one
    assign gap_hit = fall & (gap_cnt_reg < GAP_CYC);

    // trip latch, set wins over release
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trip_reg <= 1'b1;
        end else if (width_hit | react_hit | gap_hit) begin
            trip_reg <= 1'b1;
        end else if (hold_done) begin
            trip_reg <= 1'b0;
        end
    end

    // short, well spaced low pulses leave ok untouched
    assign chan_o.ok = ~trip_reg;
    assign chan_o.level = sync2_reg;
    assign chan_o.width_trip = width_hit | react_hit;
    assign chan_o.gap_trip = gap_hit;

endmodule // tcg_pulse_filter
`default_nettype wire

// >>> tcg_gate_sva.sv
// Purpose: port-level checks of the torque cutoff gating block
// Assumes: strap only changes while reset is held
// Notes: reaction bound derived from the REACT_CYC parameter
`timescale 1ns/1ps
`default_nettype none
module tcg_gate_sva
    import tcg_pkg::*;
#(
    parameter logic [TCG_REACT_W-1:0] REACT_CYC = TCG_REACT_W'(TCG_REACT_CYC)
) (
    // watched ports
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic LOCAL_ENABLE_I,
    input wire logic STRING_ENABLE_I,
    input wire logic LOCAL_FITTED_I,
    input wire logic STRING_STRING_HARDWARE_ENABLE_I,
    input wire logic DRIVE_ENABLE_REQ_I,
    input wire logic POWER_STAGE_EN_O,
    input wire logic TORQUE_EN_O,
    input wire logic DRIVE_ENABLED_O,
    input wire logic COAST_O,
    input wire logic CUTOFF_STATUS_O,
    input wire logic STRING_STATUS_O,
    input wire logic CUTOFF_EVENT_O,
    input wire logic ENABLE_REFUSED_O,
    input wire logic TEST_PULSE_TRIP_O
);
    // sync and output stages add four cycles to the filter reach
    localparam int REACT_LIM = int'(REACT_CYC) + 4;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    // cycles with the watched enable low while the stage is still released;
    // a counter, since the real reaction time is far beyond any delay range
    logic [TCG_REACT_W:0] loc_wait_reg;
    logic [TCG_REACT_W:0] str_wait_reg;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            loc_wait_reg <= '0;
            str_wait_reg <= '0;
        end else begin
            if (LOCAL_FITTED_I && !LOCAL_ENABLE_I && POWER_STAGE_EN_O) begin
                loc_wait_reg <= loc_wait_reg + 1'b1;
            end else begin
                loc_wait_reg <= '0;
            end
            if (!LOCAL_FITTED_I && !STRING_ENABLE_I && POWER_STAGE_EN_O) begin
                str_wait_reg <= str_wait_reg + 1'b1;
            end else begin
                str_wait_reg <= '0;
            end
        end
    end

    property p_sel_local;
        LOCAL_FITTED_I |-> (POWER_STAGE_EN_O == !CUTOFF_STATUS_O);
    endproperty
    a_sel_local: assert property (p_sel_local) else $error("stage not following local");
    property p_sel_string;
        !LOCAL_FITTED_I |-> (POWER_STAGE_EN_O == !STRING_STATUS_O);
    endproperty
    a_sel_string: assert property (p_sel_string) else $error("stage not following string");
    property p_react_local;
        int'(loc_wait_reg) <= REACT_LIM;
    endproperty
    a_react_local: assert property (p_react_local) else $error("local cutoff too slow");
    property p_react_string;
        int'(str_wait_reg) <= REACT_LIM;
    endproperty
    a_react_string: assert property (p_react_string) else $error("string cutoff too slow");
    property p_torque;
        TORQUE_EN_O |-> POWER_STAGE_EN_O && DRIVE_ENABLED_O && $past(STRING_STRING_HARDWARE_ENABLE_I);
    endproperty
    a_torque: assert property (p_torque) else $error("torque without all enables");
    property p_refuse;
        $rose(DRIVE_ENABLE_REQ_I) ##1 !POWER_STAGE_EN_O |-> ENABLE_REFUSED_O;
    endproperty
    a_refuse: assert property (p_refuse) else $error("blocked request not refused");
    property p_blocked;
        !POWER_STAGE_EN_O |-> !DRIVE_ENABLED_O && !TORQUE_EN_O;
    endproperty
    a_blocked: assert property (p_blocked) else $error("drive enabled while blocked");
    property p_coast;
        $fell(POWER_STAGE_EN_O) && $past(DRIVE_ENABLED_O) |-> COAST_O;
    endproperty
    a_coast: assert property (p_coast) else $error("no coast after cutoff in run");
    property p_status_fall;
        $fell(CUTOFF_STATUS_O) |-> $past(LOCAL_ENABLE_I, 4);
    endproperty
    a_status_fall: assert property (p_status_fall) else $error("status low without enable");
    property p_trip;
        TEST_PULSE_TRIP_O |=> !POWER_STAGE_EN_O;
    endproperty
    a_trip: assert property (p_trip) else $error("pulse trip left stage on");
    property p_event;
        CUTOFF_EVENT_O |-> $fell(POWER_STAGE_EN_O);
    endproperty
    a_event: assert property (p_event) else $error("event without cutoff");

    // main scenarios
    c_coast: cover property ($rose(COAST_O));
    c_refuse: cover property (ENABLE_REFUSED_O);
    c_trip: cover property (TEST_PULSE_TRIP_O);
endmodule // tcg_gate_sva

bind tcg_gate tcg_gate_sva #(.REACT_CYC(REACT_CYC)) i_sva (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .LOCAL_ENABLE_I(LOCAL_ENABLE_I),
    .STRING_ENABLE_I(STRING_ENABLE_I), .LOCAL_FITTED_I(LOCAL_FITTED_I),
    .STRING_STRING_HARDWARE_ENABLE_I(STRING_STRING_HARDWARE_ENABLE_I), .DRIVE_ENABLE_REQ_I(DRIVE_ENABLE_REQ_I),
    .POWER_STAGE_EN_O(POWER_STAGE_EN_O), .TORQUE_EN_O(TORQUE_EN_O),
    .DRIVE_ENABLED_O(DRIVE_ENABLED_O), .COAST_O(COAST_O), .CUTOFF_STATUS_O(CUTOFF_STATUS_O),
    .STRING_STATUS_O(STRING_STATUS_O), .CUTOFF_EVENT_O(CUTOFF_EVENT_O),
    .ENABLE_REFUSED_O(ENABLE_REFUSED_O), .TEST_PULSE_TRIP_O(TEST_PULSE_TRIP_O));
`default_nettype wire

// >>> tcg_safety_ctrl_model.sv
// Purpose: behavioural safety controller driving the cutoff enables
// Assumes: all changes land on the falling clock edge
// Notes: enables start absent, as after controller power up
`timescale 1ns/1ps
`default_nettype none
module tcg_safety_ctrl_model (
    // clock
    input wire logic clk_i,
    // enables and drive request
    output var logic local_en_o,
    output var logic string_en_o,
    output var logic req_o
);
    initial begin
        local_en_o = 1'b0;
        string_en_o = 1'b0;
        req_o = 1'b0;
    end
    // held high for good it bypasses the local cutoff
    task automatic set_local(input logic v);
        @(negedge clk_i);
        local_en_o = v;
    endtask
    task automatic set_string(input logic v);
        @(negedge clk_i);
        string_en_o = v;
    endtask
    task automatic set_req(input logic v);
        @(negedge clk_i);
        req_o = v;
    endtask
    // output test pulse, low for n cycles
    task automatic pulse_local(input int n);
        set_local(1'b0);
        repeat (n) @(negedge clk_i);
        local_en_o = 1'b1;
    endtask
    // disable first, remove enable afterwards
    task automatic stop_seq();
        set_req(1'b0);
        repeat (4) @(negedge clk_i);
        set_local(1'b0);
    endtask
endmodule // tcg_safety_ctrl_model
`default_nettype wire

// >>> tcg_gate_bench.sv
// Purpose: self-checking bench of the torque cutoff gating block
// Assumes: shortened filter counts keep the run brief
// Notes: inputs change on the falling edge only
`timescale 1ns/1ps
`default_nettype none
module tcg_gate_bench
    import tcg_pkg::*;
;
    localparam int W = 20;
    localparam int GAP = 200;
    localparam int REACT = 50;
    logic clk, rstn, hw, fitted;
    logic local_en, string_en, req;
    logic stage, torque, drv_en, coast, st_loc, st_str, evt, refused, trip;
    int err_count = 0, n_checks = 0, n_trip = 0, n_evt = 0, n_ref = 0;

    // 200 MHz clock
    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    tcg_safety_ctrl_model i_ctl (.clk_i(clk), .local_en_o(local_en),
        .string_en_o(string_en), .req_o(req));
    tcg_gate #(.WIDTH_CYC(TCG_WIDTH_W'(W)), .GAP_CYC(TCG_GAP_W'(GAP)),
        .REACT_CYC(TCG_REACT_W'(REACT))) i_dut (
        .CLK_I(clk), .RSTN_I(rstn), .LOCAL_ENABLE_I(local_en), .STRING_ENABLE_I(string_en),
        .LOCAL_FITTED_I(fitted), .STRING_STRING_HARDWARE_ENABLE_I(hw), .DRIVE_ENABLE_REQ_I(req),
        .POWER_STAGE_EN_O(stage), .TORQUE_EN_O(torque), .DRIVE_ENABLED_O(drv_en),
        .COAST_O(coast), .CUTOFF_STATUS_O(st_loc), .STRING_STATUS_O(st_str),
        .CUTOFF_EVENT_O(evt), .ENABLE_REFUSED_O(refused), .TEST_PULSE_TRIP_O(trip));

    // one-cycle pulses are counted mid-cycle, away from the launching edge
    always @(negedge clk) begin
        if (trip === 1'b1) n_trip++;
        if (evt === 1'b1) n_evt++;
        if (refused === 1'b1) n_ref++;
    end

    task automatic chk(input string what, input logic seen, input logic exp);
        n_checks++;
        if (seen !== exp) begin
            $display("unexpected %s: expected %b seen %b", what, exp, seen);
            err_count++;
        end
    endtask
    task automatic chk_n(input string what, input int seen, input int exp);
        n_checks++;
        if (seen != exp) begin
            $display("unexpected %s: expected %0d seen %0d", what, exp, seen);
            err_count++;
        end
    endtask
    // bounded wait, then judge the stage level
    task automatic wait_stage(input logic v, input int lim);
        int n;
        n = 0;
        while (stage !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk("power stage", stage, v);
    endtask
    task automatic do_reset(input logic fit);
        rstn = 1'b0;
        fitted = fit;
        hw = 1'b0;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
    endtask

    task automatic t_release();
        i_ctl.set_string(1'b0);
        i_ctl.set_local(1'b1);
        wait_stage(1'b1, W + 10);
        chk("local status", st_loc, 1'b0);
    endtask
    task automatic t_torque();
        i_ctl.set_req(1'b1);
        repeat (3) @(negedge clk);
        chk("drive enabled", drv_en, 1'b1);
        chk("torque hw off", torque, 1'b0);
        hw = 1'b1;
        repeat (3) @(negedge clk);
        chk("torque", torque, 1'b1);
    endtask
    task automatic t_pulses();
        // the release rise restarts the spacing count, so let it run out first
        repeat (GAP + 10) @(negedge clk);
        i_ctl.pulse_local(W - 6);
        repeat (GAP + 10) @(negedge clk);
        i_ctl.pulse_local(W - 6);
        chk("stage after pulses", stage, 1'b1);
        chk_n("events", n_evt, 0);
        repeat (10) @(negedge clk);
        i_ctl.pulse_local(W - 6);
        wait_stage(1'b0, 1);
        chk_n("pulse trips", n_trip, 1);
        chk_n("events after trip", n_evt, 1);
        chk("coast", coast, 1'b1);
        chk("torque in coast", torque, 1'b0);
        wait_stage(1'b1, 2 * W + 10);
        repeat (3) @(negedge clk);
        chk("drive back", drv_en, 1'b1);
        hw = 1'b0;
        repeat (3) @(negedge clk);
        chk("torque hw removed", torque, 1'b0);
    endtask
    task automatic t_wide();
        // space the removal from the last pulse so only the width rule acts
        repeat (GAP + 10) @(negedge clk);
        i_ctl.stop_seq();
        repeat (W - 4) @(negedge clk);
        chk("stage before width", stage, 1'b1);
        wait_stage(1'b0, REACT + 8 - W);
        chk("status absent", st_loc, 1'b1);
        chk("coast from ready", coast, 1'b0);
        i_ctl.set_req(1'b1);
        repeat (3) @(negedge clk);
        chk_n("refusals", n_ref, 1);
        chk_n("wide trips", n_trip, 2);
        chk_n("events after removal", n_evt, 2);
        chk("refused enable", drv_en, 1'b0);
        i_ctl.set_req(1'b0);
    endtask
    task automatic t_string();
        do_reset(1'b0);
        i_ctl.set_string(1'b1);
        wait_stage(1'b1, W + 10);
        chk("string status", st_str, 1'b0);
        i_ctl.set_string(1'b0);
        wait_stage(1'b0, REACT + 4);
        chk("string status cut", st_str, 1'b1);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // watchdog, well beyond the expected thousand or so cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
    initial begin
        do_reset(1'b1);
        t_release();
        t_torque();
        t_pulses();
        t_wide();
        t_string();
        tally_and_finish();
    end
endmodule // tcg_gate_bench
`default_nettype wire
